/* File: logic/dscg_gate_sel.sv */
// Picks the gating register that fits the power state and registers it.
// Assumes all inputs are on pclk; the registered result feeds latch-based clock gates.
`timescale 1ns/10ps
`default_nettype none

module dscg_gate_sel
(
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire dscg_pkg::dscg_gate_set_t gates,
   input  wire logic                    auto_gate,
   input  wire dscg_pkg::dscg_mode_t    mode,
   output var  logic [31:0]             gate_en_ff
);

   logic [31:0] nxt_gate_en; // Selected enables

   // Register chosen by auto gating and power state
   function automatic logic [31:0] pick
   (
      input dscg_pkg::dscg_gate_set_t g,
      input logic                     a,
      input dscg_pkg::dscg_mode_t     m
   );
      logic [31:0] r;
      r = g.run;
      // Without auto gating the run register always applies
      if (a && (m == dscg_pkg::MODE_SLEEP))
         r = g.sleep;
      else if (a && (m == dscg_pkg::MODE_DEEP))
         r = g.deep;
      return r & dscg_pkg::GATE_MASK;
   endfunction

   // Combinational choice
   always_comb
   begin
      nxt_gate_en = pick(gates, auto_gate, mode);
   end

   // Enables change only at an edge, so downstream gates see no glitch
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         gate_en_ff <= dscg_pkg::GATE_RESET;
      else
         gate_en_ff <= nxt_gate_en;
   end

endmodule

`default_nettype wire

/* File: logic/dscg_pkg.sv */
// Constants and types of the deep-sleep clock gating bank.
// Assumes an APB slave port on pclk, word-aligned offsets from the system control base.
package dscg_pkg;

   // Base of the system control space
   localparam logic [31:0] SYS_CTRL_BASE  = 32'h400FE000;
   // Decoded width of the offset
   localparam int unsigned OFF_W          = 12;

   // Register offsets
   localparam logic [11:0] OFF_RUN_CFG    = 12'h060;
   localparam logic [11:0] OFF_RUN_GATE   = 12'h104;
   localparam logic [11:0] OFF_SLEEP_GATE = 12'h114;
   localparam logic [11:0] OFF_DEEP_GATE  = 12'h124;
   localparam logic [11:0] OFF_IRQ_STAT   = 12'h130;
   localparam logic [11:0] OFF_IRQ_MASK   = 12'h134;

   // Gate positions inside every gating register
   localparam int unsigned COMP_LSB        = 24;
   localparam int unsigned TIMER_LSB       = 16;
   localparam int unsigned TWO_WIRE_1_BIT  = 14;
   localparam int unsigned TWO_WIRE_0_BIT  = 12;
   localparam int unsigned SYNC_SER_0_BIT  = 4;
   localparam int unsigned ASYNC_SER_LSB   = 0;
   // Writable gates: comparators, timers, two-wire, sync serial, async serial
   localparam logic [31:0] GATE_MASK       = 32'h070F5017;
   // Gating registers after reset
   localparam logic [31:0] GATE_RESET      = 32'h00000000;

   // Automatic gating select bit of the run clock configuration register
   localparam int unsigned AUTO_GATE_BIT   = 27;
   localparam logic        AUTO_RESET      = 1'b0;

   // Interrupt status layout
   localparam int unsigned IRQ_FAULT_BIT   = 0;
   localparam int unsigned IRQ_MODE_BIT    = 1;
   localparam logic [31:0] IRQ_IMPL        = 32'h00000003;
   localparam logic [31:0] IRQ_RESET       = 32'h00000000;

   // Wait states before pready
   localparam int unsigned BUS_WAIT_CYC    = 1;

   // Power state of the system
   typedef enum logic [1:0] {
      MODE_RUN,
      MODE_SLEEP,
      MODE_DEEP
   } dscg_mode_t;

   // Slave answer state
   typedef enum logic {
      BUS_IDLE,
      BUS_ANSWER
   } dscg_bus_st_t;

   // The three parallel gating registers
   typedef struct packed {
      logic [31:0] run;
      logic [31:0] sleep;
      logic [31:0] deep;
   } dscg_gate_set_t;

endpackage

/* File: logic/dscg_top.sv */
// Deep-sleep clock gating bank with its run and sleep companions, APB slave.
// Assumes power_mode and periph_req come from logic on pclk; no synchronisers needed.
`timescale 1ns/10ps
`default_nettype none

module dscg_top
#(
   parameter int unsigned ADDR_W = 12 // APB address width
)
(
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [ADDR_W-1:0]    paddr,
   input  wire logic [31:0]          pwdata,
   output var  logic [31:0]          prdata,
   output var  logic                 pready,
   output var  logic                 pslverr,
   input  wire dscg_pkg::dscg_mode_t power_mode,
   input  wire logic [31:0]          periph_req,
   output var  logic [31:0]          gate_en,
   output var  logic [31:0]          periph_fault,
   output var  logic                 irq
);

   // Refuse an address too narrow for the map
   generate
      if (ADDR_W < dscg_pkg::OFF_W)
      begin : g_chk
         $error("ADDR_W too small for the register map");
      end
   endgenerate

   // Registers
   dscg_pkg::dscg_gate_set_t gates_ff;     // Run, sleep, deep gates
   logic                     auto_ff;      // Automatic gating select
   logic [31:0]              stat_ff;      // Sticky event flags
   logic [31:0]              mask_ff;      // Interrupt mask
   dscg_pkg::dscg_bus_st_t   bus_st_ff;    // Slave answer state
   logic [31:0]              prdata_ff;    // Read data
   logic                     pready_ff;    // Ready
   logic                     pslverr_ff;   // Error
   logic [31:0]              fault_ff;     // Per-unit fault answer
   logic                     irq_ff;       // Interrupt level
   dscg_pkg::dscg_mode_t     mode_prev_ff; // Last power state
   logic [31:0]              gate_en_w;    // Selected enables (flop in leaf)

   // Decode helpers
   logic [11:0] off;        // Offset seen on the bus
   logic        access;     // Access phase present
   logic        done;       // Transfer completes this edge
   logic        wr_done;    // Write takes effect this edge
   logic        rd_done;    // Read completes this edge
   logic        mapped;     // Offset hits a register
   logic [31:0] rd_val;     // Read value of the decoded register
   logic [31:0] ev;         // Events this cycle
   logic [31:0] nxt_fault;  // Fault vector

   // True when the offset names a register
   function automatic logic hit(input logic [11:0] o);
      return (o == dscg_pkg::OFF_RUN_CFG) || (o == dscg_pkg::OFF_RUN_GATE)
          || (o == dscg_pkg::OFF_SLEEP_GATE) || (o == dscg_pkg::OFF_DEEP_GATE)
          || (o == dscg_pkg::OFF_IRQ_STAT) || (o == dscg_pkg::OFF_IRQ_MASK);
   endfunction

   // Keep only implemented gate bits
   function automatic logic [31:0] gate_w(input logic [31:0] d);
      return d & dscg_pkg::GATE_MASK;
   endfunction

   // Bus qualifiers
   assign off     = paddr[11:0];
   assign access  = psel && penable;
   assign done    = access && pready_ff;
   assign wr_done = done && pwrite && !pslverr_ff;
   assign rd_done = done && !pwrite && !pslverr_ff;
   assign mapped  = hit(off);

   // Read multiplexer
   always_comb
   begin
      rd_val = 32'h00000000;
      if (off == dscg_pkg::OFF_DEEP_GATE)
         rd_val = gates_ff.deep;
      else if (off == dscg_pkg::OFF_RUN_GATE)
         rd_val = gates_ff.run;
      else if (off == dscg_pkg::OFF_SLEEP_GATE)
         rd_val = gates_ff.sleep;
      else if (off == dscg_pkg::OFF_RUN_CFG)
         rd_val[dscg_pkg::AUTO_GATE_BIT] = auto_ff;
      else if (off == dscg_pkg::OFF_IRQ_STAT)
         rd_val = stat_ff;
      else if (off == dscg_pkg::OFF_IRQ_MASK)
         rd_val = mask_ff;
   end

   // Answer sequencer: one wait state, then pready
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         bus_st_ff <= dscg_pkg::BUS_IDLE;
      else
         case (bus_st_ff)
            dscg_pkg::BUS_IDLE:
               // First access cycle starts an answer
               if (access)
                  bus_st_ff <= dscg_pkg::BUS_ANSWER;
            dscg_pkg::BUS_ANSWER:
               // Answer given, back to idle
               bus_st_ff <= dscg_pkg::BUS_IDLE;
            default:
               bus_st_ff <= dscg_pkg::BUS_IDLE;
         endcase
   end

   // Ready, error and read data as flops
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h00000000;
      end
      else if ((bus_st_ff == dscg_pkg::BUS_IDLE) && access)
      begin
         // Capture answer for the next cycle
         pready_ff  <= 1'b1;
         pslverr_ff <= !mapped || (paddr[1:0] != 2'h0);
         prdata_ff  <= (pwrite || !mapped) ? 32'h00000000 : rd_val;
      end
      else
      begin
         // Drop after one cycle
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end
   end

   // Gating registers, written at the completing edge only
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gates_ff.run   <= dscg_pkg::GATE_RESET;
         gates_ff.sleep <= dscg_pkg::GATE_RESET;
         gates_ff.deep  <= dscg_pkg::GATE_RESET;
      end
      else if (wr_done)
      begin
         // Same layout in all three
         if (off == dscg_pkg::OFF_DEEP_GATE)
            gates_ff.deep <= gate_w(pwdata);
         else if (off == dscg_pkg::OFF_RUN_GATE)
            gates_ff.run <= gate_w(pwdata);
         else if (off == dscg_pkg::OFF_SLEEP_GATE)
            gates_ff.sleep <= gate_w(pwdata);
      end
   end

   // Automatic gating select
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         auto_ff <= dscg_pkg::AUTO_RESET;
      else if (wr_done && (off == dscg_pkg::OFF_RUN_CFG))
         auto_ff <= pwdata[dscg_pkg::AUTO_GATE_BIT];
   end

   // Interrupt mask
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mask_ff <= dscg_pkg::IRQ_RESET;
      else if (wr_done && (off == dscg_pkg::OFF_IRQ_MASK))
         mask_ff <= pwdata & dscg_pkg::IRQ_IMPL;
   end

   // Fault answer for an access to a stopped unit
   assign nxt_fault = periph_req & ~gate_en_w;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         fault_ff <= 32'h00000000;
      else
         fault_ff <= nxt_fault;
   end

   // Power state tracker
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mode_prev_ff <= dscg_pkg::MODE_RUN;
      else
         mode_prev_ff <= power_mode;
   end

   // Events for the status register
   always_comb
   begin
      ev = 32'h00000000;
      ev[dscg_pkg::IRQ_FAULT_BIT] = |nxt_fault;
      ev[dscg_pkg::IRQ_MODE_BIT]  = (power_mode != mode_prev_ff);
   end

   // Sticky status: a read clears only what it returned; set wins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         stat_ff <= dscg_pkg::IRQ_RESET;
      else if (rd_done && (off == dscg_pkg::OFF_IRQ_STAT))
         stat_ff <= (stat_ff & ~prdata_ff) | ev;
      else
         stat_ff <= stat_ff | ev;
   end

   // Interrupt level
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_ff <= 1'b0;
      else
         irq_ff <= |(stat_ff & mask_ff);
   end

   // Enable selector and its flop
   dscg_gate_sel u_sel
   (
      .pclk       (pclk),
      .presetn    (presetn),
      .gates      (gates_ff),
      .auto_gate  (auto_ff),
      .mode       (power_mode),
      .gate_en_ff (gate_en_w)
   );

   // Outputs straight from flops
   assign prdata       = prdata_ff;
   assign pready       = pready_ff;
   assign pslverr      = pslverr_ff;
   assign gate_en      = gate_en_w;
   assign periph_fault = fault_ff;
   assign irq          = irq_ff;

   // Checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Deep register is zero when reset ends
   reset_clear_a: assert property ($rose(presetn) |-> gates_ff.deep == 32'h00000000)
      else $error("deep gates not zero after reset");

   // Unused positions of the deep register never hold a one
   rsvd_zero_a: assert property ((gates_ff.deep & ~dscg_pkg::GATE_MASK) == 32'h0)
      else $error("reserved gate bit set");

   // Write at the deep offset lands masked one edge later
   deep_write_a: assert property (wr_done && (off == dscg_pkg::OFF_DEEP_GATE)
      |=> gates_ff.deep == ($past(pwdata) & dscg_pkg::GATE_MASK))
      else $error("deep gate write lost");

   // Stopped unit access answers a fault next cycle
   fault_resp_a: assert property ((periph_req & ~gate_en_w) != 32'h0
      |=> periph_fault == ($past(periph_req) & ~$past(gate_en_w)))
      else $error("missing bus fault");

   // Running unit never faults
   no_fault_a: assert property (##1 (periph_fault & $past(gate_en_w)) == 32'h0)
      else $error("fault on clocked unit");

   // Without auto gating the run register rules
   run_select_a: assert property (!auto_ff |=> gate_en == $past(gates_ff.run))
      else $error("run register not applied");

   // Deep sleep with auto gating uses the deep register
   deep_select_a: assert property (auto_ff && (power_mode == dscg_pkg::MODE_DEEP)
      |=> gate_en == $past(gates_ff.deep))
      else $error("deep register not applied");

   // Enables move only one edge after their cause, held while steady
   gate_steady_a: assert property ($stable(gates_ff) && $stable(auto_ff)
      && $stable(power_mode) |=> $stable(gate_en))
      else $error("enable changed without cause");

   // One wait state then ready
   bus_wait_a: assert property (access && !pready_ff && (bus_st_ff == dscg_pkg::BUS_IDLE)
      |=> pready ##1 !pready)
      else $error("pready timing wrong");

   // Unmapped offsets answer with error
   unmapped_a: assert property (access && (bus_st_ff == dscg_pkg::BUS_IDLE) && !mapped
      |=> pready && pslverr)
      else $error("unmapped access not refused");

   // Scenarios
   deep_wr_c: cover property (wr_done && (off == dscg_pkg::OFF_DEEP_GATE));
   fault_c:   cover property (|periph_fault);
   irq_c:     cover property ($rose(irq));
   deep_on_c: cover property (auto_ff && (power_mode == dscg_pkg::MODE_DEEP) ##1 |gate_en);

endmodule

`default_nettype wire

/* File: tb/dscg_top_tb_top.sv */
// Self-checking bench for the clock gating bank: APB master tasks and unit strobes.
// Assumes the default ADDR_W of 12 and one pclk domain at 50 MHz.
`timescale 1ns/10ps
`default_nettype none

module dscg_top_tb_top;

   logic                 pclk;         // Bus clock
   logic                 presetn;      // Async reset, active low
   logic                 psel;         // APB select
   logic                 penable;      // APB access phase
   logic                 pwrite;       // APB direction
   logic [11:0]          paddr;        // APB byte address
   logic [31:0]          pwdata;       // APB write data
   logic [31:0]          prdata;       // APB read data
   logic                 pready;       // APB completion
   logic                 pslverr;      // APB error answer
   dscg_pkg::dscg_mode_t power_mode;   // Power state
   logic [31:0]          periph_req;   // Unit access strobes
   logic [31:0]          gate_en;      // Effective clock enables
   logic [31:0]          periph_fault; // Unit fault answers
   logic                 irq;          // Level interrupt
   int                   error_cnt;    // Mismatches
   int                   samples_checked; // Comparisons
   int                   cyc;          // Timeout counter
   logic [31:0]          rd;           // Read result
   logic                 err;          // Error result
   logic [11:0]          offs [3];     // Gating register offsets
   // Writable gates: 26..24, 19..16, 14, 12, 4, 2..0
   localparam logic [31:0] EXP_MASK = 32'h070F5017;
   localparam logic [31:0] AUTO_ON  = 32'h08000000; // Bit 27

   dscg_top u_dut
   (
      .pclk         (pclk),
      .presetn      (presetn),
      .psel         (psel),
      .penable      (penable),
      .pwrite       (pwrite),
      .paddr        (paddr),
      .pwdata       (pwdata),
      .prdata       (prdata),
      .pready       (pready),
      .pslverr      (pslverr),
      .power_mode   (power_mode),
      .periph_req   (periph_req),
      .gate_en      (gate_en),
      .periph_fault (periph_fault),
      .irq          (irq)
   );

   // Free-running clock, 20 ns period
   always #10 pclk = ~pclk;

   // Closing report and verdict
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Counts one comparison, reports a mismatch
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] act);
      samples_checked++;
      if (act !== exp)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, act);
      end
   endtask

   // One APB transfer; answer taken at the rising edge where pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Values read right after the edge are the ones that edge sampled
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1)
      begin
         check("pready wait", 32'h00000001, 32'h00000000);
         // Park here; the hang guard closes the run
         wait (1'b0);
      end
      r = prdata;
      e = pslverr;
      // Release at the completing edge, so no second access is seen
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Write expecting a normal answer
   task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rd, err);
      check("write error flag", 32'h00000000, {31'h00000000, err});
   endtask

   // Read expecting a value and no error
   task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000, rd, err);
      check(what, exp, rd);
      check("read error flag", 32'h00000000, {31'h00000000, err});
   endtask

   // Waits settled cycles then compares the enables
   task automatic gate_chk(input logic [31:0] exp);
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      check("gate_en", exp, gate_en);
      // Hand back on a rising edge so the next stimulus lands there
      @(posedge pclk);
   endtask

   // Strobes units for one cycle, compares the fault answer
   task automatic req_chk(input logic [31:0] req, input logic [31:0] exp);
      @(posedge pclk);
      periph_req <= req;
      @(posedge pclk);
      periph_req <= 32'h00000000;
      @(negedge pclk);
      check("periph_fault", exp, periph_fault);
   endtask

   // Hang guard
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc > 20000)
      begin
         error_cnt++;
         give_verdict();
      end
   end

   // Main sequence
   initial
   begin
      pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h00000000; power_mode = dscg_pkg::MODE_RUN;
      periph_req = 32'h00000000; error_cnt = 0; samples_checked = 0; cyc = 0;
      offs[0] = dscg_pkg::OFF_RUN_GATE;
      offs[1] = dscg_pkg::OFF_SLEEP_GATE;
      offs[2] = dscg_pkg::OFF_DEEP_GATE;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      // All gates start cleared
      check("gate_en at reset", 32'h00000000, gate_en);
      for (int i = 0; i < 3; i++) rd_chk("gate reg reset", offs[i], 32'h00000000);
      rd_chk("deep gate at 0x124", 12'h124, 32'h00000000);
      // Only implemented gates hold ones; all three banks alike
      for (int i = 0; i < 3; i++)
      begin
         wr_reg(offs[i], 32'hFFFFFFFF);
         rd_chk("gate reg mask", offs[i], EXP_MASK);
      end
      gate_chk(EXP_MASK);
      // Unmapped and misaligned places answer an error and leave state alone
      apb(1'b1, 12'h128, 32'h00000000, rd, err);
      check("unmapped error", 32'h00000001, {31'h00000000, err});
      apb(1'b1, 12'h126, 32'h00000000, rd, err);
      check("misaligned error", 32'h00000001, {31'h00000000, err});
      check("error read data", 32'h00000000, rd);
      rd_chk("deep gate kept", dscg_pkg::OFF_DEEP_GATE, EXP_MASK);
      // Distinct patterns per bank; written back whole as software would
      wr_reg(dscg_pkg::OFF_RUN_GATE, 32'h00000001);
      wr_reg(dscg_pkg::OFF_SLEEP_GATE, 32'h00001010);
      wr_reg(dscg_pkg::OFF_DEEP_GATE, 32'h01080000);
      // Without automatic gating the run bank always applies
      for (int m = 0; m < 3; m++)
      begin
         power_mode <= dscg_pkg::dscg_mode_t'(m);
         gate_chk(32'h00000001);
      end
      // With automatic gating the bank follows the power state
      wr_reg(dscg_pkg::OFF_RUN_CFG, AUTO_ON);
      apb(1'b0, dscg_pkg::OFF_RUN_CFG, 32'h00000000, rd, err);
      check("auto select", 32'h00000001, {31'h00000000, rd[27]});
      gate_chk(32'h01080000);
      power_mode <= dscg_pkg::MODE_SLEEP;
      gate_chk(32'h00001010);
      power_mode <= dscg_pkg::MODE_RUN;
      gate_chk(32'h00000001);
      power_mode <= dscg_pkg::MODE_DEEP;
      gate_chk(32'h01080000);
      // Power changes were recorded; the read clears them
      wr_reg(dscg_pkg::OFF_IRQ_MASK, 32'h00000001);
      rd_chk("status mode", dscg_pkg::OFF_IRQ_STAT, 32'h00000002);
      rd_chk("status cleared", dscg_pkg::OFF_IRQ_STAT, 32'h00000000);
      check("irq idle", 32'h00000000, {31'h00000000, irq});
      // Clocked units answer, gated units fault
      req_chk(32'h01080000, 32'h00000000);
      req_chk(32'h00001011, 32'h00001011);
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      check("irq raised", 32'h00000001, {31'h00000000, irq});
      rd_chk("status fault", dscg_pkg::OFF_IRQ_STAT, 32'h00000001);
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      check("irq cleared", 32'h00000000, {31'h00000000, irq});
      // Masked fault keeps the line low
      wr_reg(dscg_pkg::OFF_IRQ_MASK, 32'h00000000);
      req_chk(32'h00000004, 32'h00000004);
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      check("irq masked", 32'h00000000, {31'h00000000, irq});
      rd_chk("status masked", dscg_pkg::OFF_IRQ_STAT, 32'h00000001);
      // Mid-run reset clears every bank
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 3; i++) rd_chk("gate reg re-reset", offs[i], 32'h00000000);
      gate_chk(32'h00000000);
      give_verdict();
   end

endmodule

`default_nettype wire
